// ---- design/uafc_top.sv ----
// Purpose: baud divisor, scratch, enhanced features and automatic flow control
// Assumes: receive fill level is a live count from the receive fifo
// Notes:   zero-wait apb slave; control characters go out via tx_ctrl_*
//
// Behaviour
// - bit tick is clock over sixteen times divisor, baud16 tick clock over divisor
// - divisor is low byte plus 256 times high
// - scratch stores bytes and indexes indexed registers
// - key write opens features, sets bit 7 only
// - nine-bit framing disables all in-band flow control
// - receive mode picks set 2, set 1 or off
// - receive mode 11 accepts either character set
// - transmit mode picks set 2, set 1 or off
// - enhanced bit clear disables all enhanced features
// - out-of-band enable from feature bits or modem bit
// - pause 2 special match stored, flagged, level 5
// - character errors never block matches
// - pause stops transmit, sets status; resume clears
// - pause and resume characters discarded, except special
// - resume-on-any restarts transmit, keeps the character
// - idle transmitter sends pause or resume by level
// - disabling transmit flow sends outstanding resume
// - auto request-to-send follows fill level thresholds
// - auto request-to-send anded with software bit
// - clear-to-send inactive withholds new characters
// - terminal-ready/set-ready pair mirrors request/clear pair
// - level 5 reports code 010000, cleared on read
`timescale 1ns/1ps
module uafc_top
	import uafc_pkg::*;
(
	// apb
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// receiver
	input  wire logic        rx_valid,
	input  wire logic [7:0]  rx_data,
	input  wire logic        rx_error,
	input  wire logic [7:0]  rx_fill_level,
	output logic             rx_store,
	output logic      [7:0]  rx_store_data,
	// transmitter
	input  wire logic        tx_idle,
	output logic             tx_hold,
	output logic             tx_ctrl_send,
	output logic      [7:0]  tx_ctrl_char,
	// modem lines
	input  wire logic        cts_n,
	input  wire logic        dsr_n,
	output logic             rts_n,
	output logic             dtr_n,
	// baud and level 5
	output logic             baud16_tick,
	output logic             baud_bit_tick,
	output logic             level5_irq
);
	import uafc_pkg::*;

	typedef struct packed {
		logic [7:0]  line_format_control;
		logic        key_open;
		logic [7:0]  divisor_low_byte;
		logic [7:0]  divisor_high_byte;
		logic [7:0]  scratch_byte;
		logic [7:0]  enhanced_features;
		logic [7:0]  modem_control;
		logic [7:0]  interrupt_enable_mask;
		logic [7:0]  additional_control;
		logic [7:0]  resume_char_1;
		logic [7:0]  resume_char_2;
		logic [7:0]  pause_char_1;
		logic [7:0]  pause_char_2;
		logic [7:0]  upper_thr;
		logic [7:0]  lower_thr;
		logic        paused;
		logic        lvl5;
		logic        special;
		logic        sent_pause;
		logic        resume_set1;
		logic        rts_block;
		logic        dtr_block;
		logic [15:0] div_cnt;
		logic [3:0]  smp_cnt;
		logic        baud16;
		logic        baudbit;
		logic        tx_send;
		logic [7:0]  tx_char;
		logic        hold;
		logic        rts_n;
		logic        dtr_n;
		logic        store;
		logic [7:0]  store_data;
		logic        irq;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} uafc_state_t;

	uafc_state_t s_q;
	uafc_state_t s_d;

	// decoded modes
	logic        enh;
	logic        nine;
	logic [1:0]  rx_mode;
	logic [1:0]  tx_mode;
	logic        tx_flow_on;
	logic        m_p1;
	logic        m_p2;
	logic        m_r1;
	logic        m_r2;
	logic        pause_hit;
	logic        resume_hit;
	logic        any_hit;
	logic        special_hit;
	logic        acc;
	logic        wr;
	logic        rd;
	logic [15:0] divisor;
	logic        lvl5_on;

	assign enh        = s_q.enhanced_features[ENH_MODE];
	assign nine       = s_q.additional_control[ACR_NINE];
	assign rx_mode    = (enh && !nine) ?
		s_q.enhanced_features[ENH_RX_LO +: 2] : 2'b00;
	assign tx_mode    = (enh && !nine) ?
		s_q.enhanced_features[ENH_TX_LO +: 2] : 2'b00;
	assign tx_flow_on = (tx_mode == 2'b01) || (tx_mode == 2'b10);
	// matches look only at the data byte, never at rx_error
	assign m_p1 = rx_data == s_q.pause_char_1;
	assign m_p2 = rx_data == s_q.pause_char_2;
	assign m_r1 = rx_data == s_q.resume_char_1;
	assign m_r2 = rx_data == s_q.resume_char_2;
	assign pause_hit = rx_valid && (
		(rx_mode == 2'b01 && m_p2) ||
		(rx_mode == 2'b10 && m_p1) ||
		(rx_mode == 2'b11 && (m_p1 || m_p2)));
	assign resume_hit = rx_valid && (
		(rx_mode == 2'b01 && m_r2) ||
		(rx_mode == 2'b10 && m_r1) ||
		(rx_mode == 2'b11 && (m_r1 || m_r2)));
	assign any_hit = rx_valid && enh && s_q.modem_control[MCR_AUTO];
	assign special_hit = rx_valid && enh &&
		s_q.enhanced_features[ENH_SPECIAL] && m_p2;
	assign acc = psel && penable && s_q.pready;
	assign wr  = acc && pwrite;
	assign rd  = acc && !pwrite;
	assign divisor = {s_q.divisor_high_byte, s_q.divisor_low_byte};
	assign lvl5_on = s_q.lvl5 && enh &&
		s_q.interrupt_enable_mask[IER_LVL5];

	always_comb begin
		logic        auto_rt;
		logic        auto_cl;
		logic [7:0]  rdv;
		logic        hit;
		auto_rt = 1'b0;
		auto_cl = 1'b0;
		rdv     = 8'h00;
		hit     = 1'b1;
		s_d = s_q;
		s_d.baud16  = 1'b0;
		s_d.baudbit = 1'b0;
		s_d.tx_send = 1'b0;
		s_d.store   = 1'b0;

		// apb: one access cycle after every setup cycle
		s_d.pready = psel && !penable;
		unique case (paddr)
			OFS_LINE_FMT:  rdv = s_q.line_format_control;
			OFS_DIV_LOW:   rdv = s_q.divisor_low_byte;
			OFS_DIV_HIGH:  rdv = s_q.divisor_high_byte;
			OFS_SCRATCH:   rdv = s_q.scratch_byte;
			OFS_ENH_FEAT:  rdv = s_q.enhanced_features;
			OFS_MODEM_CTL: rdv = s_q.modem_control;
			OFS_INT_MASK:  rdv = s_q.interrupt_enable_mask;
			OFS_INT_SRC:   rdv = lvl5_on ? INT_SRC_LVL5 : INT_SRC_NONE;
			OFS_ADD_STAT:  rdv = {3'b000, s_q.special, 2'b00,
				s_q.sent_pause, s_q.paused};
			OFS_ADD_CTL:   rdv = s_q.additional_control;
			OFS_RESUME1:   rdv = s_q.resume_char_1;
			OFS_RESUME2:   rdv = s_q.resume_char_2;
			OFS_PAUSE1:    rdv = s_q.pause_char_1;
			OFS_PAUSE2:    rdv = s_q.pause_char_2;
			OFS_INDEXED: begin
				if (s_q.scratch_byte == IDX_UPPER_THR) begin
					rdv = s_q.upper_thr;
				end else if (s_q.scratch_byte == IDX_LOWER_THR) begin
					rdv = s_q.lower_thr;
				end
			end
			default:       hit = 1'b0;
		endcase
		// read data and error are settled during setup
		if (psel && !penable) begin
			s_d.prdata  = {24'h00_0000, rdv};
			s_d.pslverr = !hit;
		end

		if (wr && hit) begin
			unique case (paddr)
				OFS_LINE_FMT: begin
					if (pwdata[7:0] == LINE_FMT_KEY) begin
						s_d.line_format_control[7] = 1'b1;
						s_d.key_open = 1'b1;
					end else begin
						s_d.line_format_control = pwdata[7:0];
						s_d.key_open = 1'b0;
					end
				end
				OFS_DIV_LOW:   s_d.divisor_low_byte = pwdata[7:0];
				OFS_DIV_HIGH:  s_d.divisor_high_byte = pwdata[7:0];
				OFS_SCRATCH:   s_d.scratch_byte = pwdata[7:0];
				OFS_ENH_FEAT: begin
					if (s_q.key_open) begin
						s_d.enhanced_features = pwdata[7:0];
					end
				end
				OFS_MODEM_CTL: s_d.modem_control = pwdata[7:0];
				OFS_INT_MASK:  s_d.interrupt_enable_mask = pwdata[7:0];
				OFS_ADD_CTL:   s_d.additional_control = pwdata[7:0];
				OFS_RESUME1:   s_d.resume_char_1 = pwdata[7:0];
				OFS_RESUME2:   s_d.resume_char_2 = pwdata[7:0];
				OFS_PAUSE1:    s_d.pause_char_1 = pwdata[7:0];
				OFS_PAUSE2:    s_d.pause_char_2 = pwdata[7:0];
				OFS_INDEXED: begin
					if (s_q.scratch_byte == IDX_UPPER_THR) begin
						s_d.upper_thr = pwdata[7:0];
					end else if (s_q.scratch_byte == IDX_LOWER_THR) begin
						s_d.lower_thr = pwdata[7:0];
					end
				end
				default: ;
			endcase
		end

		// baud: divisor zero stops the ticks rather than dividing by 65536
		if (divisor != 16'h0000) begin
			if (s_q.div_cnt >= divisor - 16'h0001) begin
				s_d.div_cnt = 16'h0000;
				s_d.baud16  = 1'b1;
				s_d.smp_cnt = s_q.smp_cnt + 4'h1;
				s_d.baudbit = s_q.smp_cnt == OVERSAMPLE_LAST;
			end else begin
				s_d.div_cnt = s_q.div_cnt + 16'h0001;
			end
		end else begin
			s_d.div_cnt = 16'h0000;
		end

		// clears first so that a same-cycle event wins
		if (rd && paddr == OFS_INT_SRC && lvl5_on) begin
			s_d.lvl5 = 1'b0;
		end
		if (rd && paddr == OFS_ADD_STAT) begin
			s_d.special = 1'b0;
		end
		if (rx_mode == 2'b00) begin
			s_d.paused = 1'b0;
		end
		if (resume_hit || (any_hit && s_q.paused)) begin
			s_d.paused = 1'b0;
			s_d.lvl5   = 1'b0;
		end
		if (pause_hit) begin
			s_d.paused = 1'b1;
			s_d.lvl5   = 1'b1;
		end
		if (special_hit) begin
			s_d.special = 1'b1;
			s_d.lvl5    = 1'b1;
		end
		if (rx_valid && (!(pause_hit || resume_hit) || special_hit)) begin
			s_d.store      = 1'b1;
			s_d.store_data = rx_data;
		end

		// spacing of one cycle gives the transmitter time to drop idle
		if (tx_idle && !s_q.tx_send) begin
			if (tx_flow_on) begin
				if (rx_fill_level > s_q.upper_thr && !s_q.sent_pause) begin
					s_d.tx_send     = 1'b1;
					s_d.tx_char     = tx_mode == 2'b01 ?
						s_q.pause_char_2 : s_q.pause_char_1;
					s_d.sent_pause  = 1'b1;
					s_d.resume_set1 = tx_mode == 2'b10;
				end else if (rx_fill_level < s_q.lower_thr &&
					s_q.sent_pause) begin
					s_d.tx_send    = 1'b1;
					s_d.tx_char    = tx_mode == 2'b01 ?
						s_q.resume_char_2 : s_q.resume_char_1;
					s_d.sent_pause = 1'b0;
				end
			end else if (s_q.sent_pause) begin
				s_d.tx_send    = 1'b1;
				s_d.tx_char    = s_q.resume_set1 ?
					s_q.resume_char_1 : s_q.resume_char_2;
				s_d.sent_pause = 1'b0;
			end
		end

		auto_rt = enh ? s_q.enhanced_features[ENH_AUTO_RT] :
			s_q.modem_control[MCR_AUTO];
		auto_cl = enh ? s_q.enhanced_features[ENH_AUTO_CL] :
			s_q.modem_control[MCR_AUTO];
		if (rx_fill_level >= s_q.upper_thr) begin
			s_d.rts_block = 1'b1;
			s_d.dtr_block = 1'b1;
		end else if (rx_fill_level < s_q.lower_thr) begin
			s_d.rts_block = 1'b0;
			s_d.dtr_block = 1'b0;
		end
		s_d.rts_n = !(s_q.modem_control[MCR_RTS] &&
			!(auto_rt && s_q.rts_block));
		s_d.dtr_n = !(s_q.modem_control[MCR_DTR] &&
			!(s_q.additional_control[ACR_AUTO_TR] && s_q.dtr_block));
		// hold only stops new characters; the one on the line finishes
		s_d.hold = s_q.paused || (auto_cl && cts_n) ||
			(s_q.additional_control[ACR_AUTO_SR] && dsr_n);
		s_d.irq = lvl5_on;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
			s_q.divisor_low_byte <= RST_DIV_LOW;
			s_q.upper_thr        <= RST_UPPER_THR;
			s_q.lower_thr        <= RST_LOWER_THR;
			s_q.rts_n            <= 1'b1;
			s_q.dtr_n            <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata        = s_q.prdata;
	assign pready        = s_q.pready;
	assign pslverr       = s_q.pslverr;
	assign rx_store      = s_q.store;
	assign rx_store_data = s_q.store_data;
	assign tx_hold       = s_q.hold;
	assign tx_ctrl_send  = s_q.tx_send;
	assign tx_ctrl_char  = s_q.tx_char;
	assign rts_n         = s_q.rts_n;
	assign dtr_n         = s_q.dtr_n;
	assign baud16_tick   = s_q.baud16;
	assign baud_bit_tick = s_q.baudbit;
	assign level5_irq    = s_q.irq;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_pause_rx;
		pause_hit && !any_hit;
	endsequence
	sequence s_held_two;
		tx_hold [*2];
	endsequence

	a_pause_holds_tx: assert property (s_pause_rx |=> ##1 s_held_two)
		else $error("pause did not hold transmitter");
	a_rts_sw_force: assert property (
		!s_q.modem_control[MCR_RTS] |=> rts_n)
		else $error("rts not forced inactive");
	a_special_stored: assert property (special_hit |=>
		rx_store && rx_store_data == $past(rx_data) && s_q.special)
		else $error("special character not stored");
	a_pause_dropped: assert property (
		(pause_hit && !special_hit) |=> !rx_store)
		else $error("pause character stored");
	a_nine_no_pause: assert property (
		(nine && rx_valid && !s_q.paused) |=> !s_q.paused)
		else $error("in-band pause in nine-bit mode");
	a_lvl5_rd_clear: assert property (
		(rd && paddr == OFS_INT_SRC && lvl5_on && !pause_hit &&
		!special_hit) |=> !s_q.lvl5)
		else $error("level 5 not cleared by read");
	a_ctrl_spacing: assert property (
		tx_ctrl_send |=> !tx_ctrl_send)
		else $error("control characters back to back");
	a_apb_one_wait: assert property (
		(psel && !penable) |=> pready)
		else $error("apb access not answered");
	a_key_locked: assert property (
		(wr && paddr == OFS_ENH_FEAT && !s_q.key_open) |=>
		$stable(s_q.enhanced_features))
		else $error("feature register written while locked");
	a_baud_rate: assert property (
		(baud16_tick && divisor == 16'h0002 && $stable(divisor)) |=>
		!baud16_tick ##1 baud16_tick)
		else $error("baud tick spacing wrong");

endmodule : uafc_top

// ---- design/uafc_pkg.sv ----
// Purpose: constants and register map for the serial flow-control block
// Assumes: 32-bit apb data, one register per aligned word
// Notes:   divisor, scratch, feature and control registers share one map
package uafc_pkg;

	// register byte offsets
	localparam logic [7:0] OFS_LINE_FMT   = 8'h00;
	localparam logic [7:0] OFS_DIV_LOW    = 8'h04;
	localparam logic [7:0] OFS_DIV_HIGH   = 8'h08;
	localparam logic [7:0] OFS_SCRATCH    = 8'h0C;
	localparam logic [7:0] OFS_ENH_FEAT   = 8'h10;
	localparam logic [7:0] OFS_MODEM_CTL  = 8'h14;
	localparam logic [7:0] OFS_INT_MASK   = 8'h18;
	localparam logic [7:0] OFS_INT_SRC    = 8'h1C;
	localparam logic [7:0] OFS_ADD_STAT   = 8'h20;
	localparam logic [7:0] OFS_ADD_CTL    = 8'h24;
	localparam logic [7:0] OFS_RESUME1    = 8'h28;
	localparam logic [7:0] OFS_RESUME2    = 8'h2C;
	localparam logic [7:0] OFS_PAUSE1     = 8'h30;
	localparam logic [7:0] OFS_PAUSE2     = 8'h34;
	localparam logic [7:0] OFS_INDEXED    = 8'h38;

	// indexed registers, picked by the scratch byte
	localparam logic [7:0] IDX_UPPER_THR  = 8'h00;
	localparam logic [7:0] IDX_LOWER_THR  = 8'h01;

	// special values
	localparam logic [7:0] LINE_FMT_KEY   = 8'hBF;
	localparam logic [7:0] INT_SRC_LVL5   = 8'h10;
	localparam logic [7:0] INT_SRC_NONE   = 8'h01;

	// field positions
	localparam int ENH_RX_LO   = 0;
	localparam int ENH_TX_LO   = 2;
	localparam int ENH_MODE    = 4;
	localparam int ENH_SPECIAL = 5;
	localparam int ENH_AUTO_RT = 6;
	localparam int ENH_AUTO_CL = 7;
	localparam int MCR_DTR     = 0;
	localparam int MCR_RTS     = 1;
	localparam int MCR_AUTO    = 5;
	localparam int IER_LVL5    = 5;
	localparam int ACR_NINE    = 0;
	localparam int ACR_AUTO_TR = 2;
	localparam int ACR_AUTO_SR = 3;
	localparam int ASR_PAUSED  = 0;
	localparam int ASR_SENT    = 1;
	localparam int ASR_SPECIAL = 4;

	// reset values and last oversample count
	localparam logic [7:0]  RST_DIV_LOW   = 8'h01;
	localparam logic [7:0]  RST_UPPER_THR = 8'h60;
	localparam logic [7:0]  RST_LOWER_THR = 8'h20;
	localparam logic [3:0]  OVERSAMPLE_LAST = 4'hF;

endpackage : uafc_pkg

// ---- dv/uafc_remote.sv ----
// Purpose: remote serial peer and local transmitter pacing model
// Assumes: one received character per rx_valid pulse
// Notes:   tx_idle drops while an inserted control character is on the line
`timescale 1ns/1ps
module uafc_remote (
	// clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// from the block
	input  wire logic       tx_ctrl_send,
	input  wire logic [7:0] tx_ctrl_char,
	// to the block
	output logic            rx_valid,
	output logic      [7:0] rx_data,
	output logic            rx_error,
	output logic            tx_idle
);
	logic [7:0] sent_q;
	int         sent_n;
	int         busy;
	initial begin
		rx_valid = 1'b0;
		rx_data  = 8'h5A;
		rx_error = 1'b0;
	end
	// control characters hold the line for a few cycles
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy    <= 0;
			sent_n  <= 0;
			tx_idle <= 1'b1;
		end else if (tx_ctrl_send) begin
			sent_q  <= tx_ctrl_char;
			sent_n  <= sent_n + 1;
			busy    <= 4;
			tx_idle <= 1'b0;
		end else if (busy > 1) begin
			busy <= busy - 1;
		end else begin
			busy    <= 0;
			tx_idle <= 1'b1;
		end
	end
	// bad line status on purpose; released data shows its inverse
	task automatic send(input logic [7:0] c);
		@(posedge pclk);
		rx_valid <= 1'b1;
		rx_data  <= c;
		rx_error <= 1'b1;
		@(posedge pclk);
		rx_valid <= 1'b0;
		rx_data  <= ~c;
		rx_error <= 1'b0;
	endtask : send
endmodule : uafc_remote

// ---- dv/uart_auto_flow_control_tb.sv ----
// Purpose: self-checking bench for the flow-control block
// Assumes: zero-wait apb slave, control characters via uafc_remote
// Notes:   register rows first, then hand-written flow cases
`timescale 1ns/1ps
module uart_auto_flow_control_tb;
	import uafc_pkg::*;
	typedef struct packed {
		logic       w;
		logic [7:0] a;
		logic [7:0] d;
		logic [7:0] e;
	} uafc_row_t;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr, rx_data, rx_fill_level, rx_store_data, tx_ctrl_char;
	logic [31:0] pwdata, prdata, rd;
	logic        rx_valid, rx_error, rx_store, tx_idle, tx_hold, perr;
	logic        tx_ctrl_send, cts_n, dsr_n, rts_n, dtr_n, level5_irq;
	logic        baud16_tick, baud_bit_tick;
	int          fails, n_tests, n;
	uafc_row_t   rows [21] = '{
		'{1'b0, OFS_DIV_LOW, 8'h00, 8'h01}, '{1'b1, OFS_SCRATCH, 8'h01, 8'h01},
		'{1'b0, OFS_INDEXED, 8'h00, 8'h20}, '{1'b1, OFS_SCRATCH, 8'h00, 8'h00},
		'{1'b0, OFS_INDEXED, 8'h00, 8'h60}, '{1'b1, OFS_LINE_FMT, 8'h03, 8'h03},
		'{1'b1, OFS_ENH_FEAT, 8'hD0, 8'h00}, '{1'b1, OFS_LINE_FMT, 8'hBF, 8'h83},
		'{1'b1, OFS_ENH_FEAT, 8'h12, 8'h12}, '{1'b1, OFS_DIV_HIGH, 8'h00, 8'h00},
		'{1'b1, OFS_DIV_LOW, 8'h03, 8'h03}, '{1'b1, OFS_RESUME1, 8'h11, 8'h11},
		'{1'b1, OFS_RESUME2, 8'h21, 8'h21}, '{1'b1, OFS_PAUSE1, 8'h13, 8'h13},
		'{1'b1, OFS_PAUSE2, 8'h23, 8'h23}, '{1'b1, OFS_INT_MASK, 8'h20, 8'h20},
		'{1'b1, OFS_MODEM_CTL, 8'h03, 8'h03}, '{1'b1, OFS_ADD_CTL, 8'h00, 8'h00},
		'{1'b1, 8'hFC, 8'h77, 8'h00}, '{1'b1, OFS_SCRATCH, 8'hA5, 8'hA5},
		'{1'b0, OFS_INDEXED, 8'h00, 8'h00}};
	logic [7:0]  chars [4] = '{8'h13, 8'h23, 8'h11, 8'h21};
	logic [7:0]  enh [3] = '{8'h11, 8'h12, 8'h17};
	logic [3:0]  st [3] = '{4'b0101, 4'b1010, 4'b0000};
	logic [7:0]  txe [2] = '{8'h14, 8'h18};
	logic [7:0]  pz [2] = '{8'h23, 8'h13};
	logic [7:0]  rs [2] = '{8'h21, 8'h11};

	uafc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rx_valid(rx_valid), .rx_data(rx_data), .rx_error(rx_error),
		.rx_fill_level(rx_fill_level), .rx_store(rx_store),
		.rx_store_data(rx_store_data), .tx_idle(tx_idle), .tx_hold(tx_hold),
		.tx_ctrl_send(tx_ctrl_send), .tx_ctrl_char(tx_ctrl_char),
		.cts_n(cts_n), .dsr_n(dsr_n), .rts_n(rts_n), .dtr_n(dtr_n),
		.baud16_tick(baud16_tick), .baud_bit_tick(baud_bit_tick),
		.level5_irq(level5_irq));
	uafc_remote rem (.pclk(pclk), .presetn(presetn),
		.tx_ctrl_send(tx_ctrl_send), .tx_ctrl_char(tx_ctrl_char),
		.rx_valid(rx_valid), .rx_data(rx_data), .rx_error(rx_error),
		.tx_idle(tx_idle));

	always #2.5 pclk = ~pclk;

	task automatic test_done();
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : test_done
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			fails++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int i;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= {24'h00_0000, d};
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		if (pready !== 1'b1) begin
			fails++;
			test_done();
		end
		rd = prdata;
		perr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic waitn(input int k);
		repeat (k) @(posedge pclk);
		#1;
	endtask : waitn
	// one character in; store pulse is one cycle, so look right away
	task automatic rx(input logic [7:0] c, input logic s);
		rem.send(c);
		#1;
		chk(rx_store, s);
		if (s) chk(rx_store_data, c);
	endtask : rx
	task automatic set_fill(input logic [7:0] v);
		@(posedge pclk);
		rx_fill_level <= v;
	endtask : set_fill
	task automatic sent(input logic [7:0] c);
		int k, n0;
		n0 = rem.sent_n;
		k = 0;
		while (rem.sent_n == n0 && k < 50) begin
			@(posedge pclk);
			#1;
			k++;
		end
		if (k >= 50) begin
			fails++;
			test_done();
		end
		chk(rem.sent_q, c);
	endtask : sent
	// distance between two pulses of one tick output
	task automatic gap(input logic b, output int g);
		int k;
		k = 0;
		g = 0;
		// step off the edge so every look sees settled tick values
		#1;
		while ((b ? baud_bit_tick : baud16_tick) !== 1'b1 && k < 1000) begin
			@(posedge pclk);
			#1;
			k++;
		end
		do begin
			@(posedge pclk);
			#1;
			g++;
		end while ((b ? baud_bit_tick : baud16_tick) !== 1'b1 && g < 1000);
		if (g >= 1000) begin
			fails++;
			test_done();
		end
	endtask : gap

	initial begin
		{pclk, presetn, psel, penable, pwrite, cts_n, dsr_n} = '0;
		{paddr, pwdata, rx_fill_level, fails, n_tests} = '0;
		repeat (3) @(posedge pclk);
		chk(rts_n, 1'b1);
		chk(dtr_n, 1'b1);
		presetn <= 1'b1;
		foreach (rows[i]) begin
			if (rows[i].w) apb(1'b1, rows[i].a, rows[i].d);
			apb(1'b0, rows[i].a, 8'h00);
			chk(rd, rows[i].e);
			chk(perr, rows[i].a == 8'hFC);
		end
		gap(1'b0, n);
		chk(n, 3);
		gap(1'b1, n);
		chk(n, 48);
		apb(1'b1, OFS_DIV_HIGH, 8'h01);
		apb(1'b1, OFS_DIV_LOW, 8'h02);
		gap(1'b0, n);
		chk(n, 258);
		apb(1'b1, OFS_DIV_HIGH, 8'h00);
		gap(1'b0, n);
		chk(n, 2);
		for (int m = 0; m < 3; m++) begin
			apb(1'b1, OFS_ENH_FEAT, enh[m]);
			for (int c = 0; c < 4; c++) rx(chars[c], st[m][c]);
		end
		apb(1'b1, OFS_ENH_FEAT, 8'h12);
		rx(8'h13, 1'b0);
		waitn(2);
		chk(tx_hold, 1'b1);
		chk(level5_irq, 1'b1);
		apb(1'b0, OFS_ADD_STAT, 8'h00);
		chk(rd, 8'h01);
		apb(1'b0, OFS_INT_SRC, 8'h00);
		chk(rd, 8'h10);
		apb(1'b0, OFS_INT_SRC, 8'h00);
		chk(rd, 8'h01);
		rx(8'h11, 1'b0);
		waitn(2);
		chk(tx_hold, 1'b0);
		apb(1'b1, OFS_MODEM_CTL, 8'h23);
		rx(8'h13, 1'b0);
		waitn(2);
		chk(tx_hold, 1'b1);
		rx(8'h41, 1'b1);
		waitn(2);
		chk(tx_hold, 1'b0);
		apb(1'b1, OFS_MODEM_CTL, 8'h03);
		apb(1'b0, OFS_INT_SRC, 8'h00);
		apb(1'b1, OFS_ENH_FEAT, 8'h30);
		rx(8'h23, 1'b1);
		waitn(2);
		chk(level5_irq, 1'b1);
		apb(1'b0, OFS_ADD_STAT, 8'h00);
		chk(rd, 8'h10);
		apb(1'b0, OFS_ADD_STAT, 8'h00);
		chk(rd, 8'h00);
		apb(1'b0, OFS_INT_SRC, 8'h00);
		waitn(1);
		chk(level5_irq, 1'b0);
		apb(1'b1, OFS_ADD_CTL, 8'h01);
		apb(1'b1, OFS_ENH_FEAT, 8'h12);
		rx(8'h13, 1'b1);
		apb(1'b1, OFS_ADD_CTL, 8'h00);
		apb(1'b1, OFS_ENH_FEAT, 8'h02);
		rx(8'h13, 1'b1);
		waitn(2);
		chk(tx_hold, 1'b0);
		for (int t = 0; t < 2; t++) begin
			apb(1'b1, OFS_ENH_FEAT, txe[t]);
			set_fill(8'h61);
			sent(pz[t]);
			apb(1'b0, OFS_ADD_STAT, 8'h00);
			chk(rd, 8'h02);
			set_fill(8'h1F);
			sent(rs[t]);
			set_fill(8'h61);
			sent(pz[t]);
			apb(1'b1, OFS_ENH_FEAT, 8'h10);
			sent(rs[t]);
			set_fill(8'h00);
		end
		apb(1'b1, OFS_ENH_FEAT, 8'h50);
		waitn(2);
		chk(rts_n, 1'b0);
		set_fill(8'h60);
		waitn(2);
		chk(rts_n, 1'b1);
		set_fill(8'h20);
		waitn(2);
		chk(rts_n, 1'b1);
		set_fill(8'h1F);
		waitn(2);
		chk(rts_n, 1'b0);
		apb(1'b1, OFS_MODEM_CTL, 8'h01);
		waitn(2);
		chk(rts_n, 1'b1);
		apb(1'b1, OFS_MODEM_CTL, 8'h03);
		apb(1'b1, OFS_ENH_FEAT, 8'h90);
		cts_n <= 1'b1;
		waitn(3);
		chk(tx_hold, 1'b1);
		cts_n <= 1'b0;
		waitn(3);
		chk(tx_hold, 1'b0);
		apb(1'b1, OFS_ENH_FEAT, 8'h80);
		cts_n <= 1'b1;
		waitn(3);
		chk(tx_hold, 1'b0);
		apb(1'b1, OFS_MODEM_CTL, 8'h23);
		waitn(3);
		chk(tx_hold, 1'b1);
		apb(1'b1, OFS_MODEM_CTL, 8'h03);
		cts_n <= 1'b0;
		apb(1'b1, OFS_ENH_FEAT, 8'h00);
		apb(1'b1, OFS_ADD_CTL, 8'h0C);
		dsr_n <= 1'b1;
		waitn(3);
		chk(tx_hold, 1'b1);
		dsr_n <= 1'b0;
		set_fill(8'h60);
		waitn(2);
		chk(dtr_n, 1'b1);
		set_fill(8'h00);
		waitn(2);
		chk(dtr_n, 1'b0);
		test_done();
	end
endmodule : uart_auto_flow_control_tb
